// File: ddr_output_reg_read_polarity.sv
// Per-pin SDR/DDR output register and read-side synchronizing clock polarity selection.
`timescale 1ns/100ps
`default_nettype none
module ddr_output_reg_read_polarity #(
    parameter int DATA_W = 1
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire ddr_out_pkg::pin_sample_t pins,
    input  wire ddr_out_pkg::out_mode_t   outMode,
    input  wire logic                     outCe,
    input  wire logic                     outRst,
    input  wire logic [DATA_W-1:0]        out_data_negphase,
    input  wire logic [DATA_W-1:0]        out_data_posphase,
    output logic      [DATA_W-1:0]        pin_output_data,
    input  wire logic                     readStart,
    input  wire logic [DATA_W-1:0]        readData,
    output logic      [DATA_W-1:0]        readCapture,
    output logic                          syncFall,
    output logic                          preambleSeen
);

    // ========================================================================
    // Elaboration checks
    if (DATA_W < 1) begin : g_bad_width
        $error("DATA_W must be at least one.");
    end
    if (ddr_out_pkg::SYNC_STAGES != 3) begin : g_bad_sync
        $error("The pin synchroniser is built for exactly three stages.");
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ========================================================================
    // Pin synchronisers
    // The third stage only confirms the second, so a metastable first stage never reaches logic.
    logic [ddr_out_pkg::PIN_COUNT-1:0] syncA;
    logic [ddr_out_pkg::PIN_COUNT-1:0] syncB;
    logic [ddr_out_pkg::PIN_COUNT-1:0] syncC;
    logic [ddr_out_pkg::PIN_COUNT-1:0] filt;
    logic [ddr_out_pkg::PIN_COUNT-1:0] filtQ;

    genvar gi;
    for (gi = 0; gi < ddr_out_pkg::PIN_COUNT; gi++) begin : g_sync
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                syncA[gi] <= ddr_out_pkg::SYNC_RST[0];
                syncB[gi] <= ddr_out_pkg::SYNC_RST[1];
                syncC[gi] <= ddr_out_pkg::SYNC_RST[2];
                filt[gi]  <= ddr_out_pkg::SYNC_RST[2];
                filtQ[gi] <= ddr_out_pkg::SYNC_RST[2];
            end else begin
                syncA[gi] <= pins[gi];
                syncB[gi] <= syncA[gi];
                syncC[gi] <= syncB[gi];
                if (syncB[gi] == syncC[gi]) begin
                    filt[gi] <= syncB[gi];
                end
                filtQ[gi] <= filt[gi];
            end
        end
    end

    logic clkHigh;
    logic clkRise;
    logic clkFall;
    logic dqsIdle;
    logic dqsIdleQ;
    logic dqsLowNow;

    assign clkHigh   = filt[ddr_out_pkg::PIN_IO_CLK];
    assign clkRise   = clkHigh & ~filtQ[ddr_out_pkg::PIN_IO_CLK];
    assign clkFall   = ~clkHigh & filtQ[ddr_out_pkg::PIN_IO_CLK];
    assign dqsLowNow = filt[ddr_out_pkg::PIN_DQS_LOW] & ~filt[ddr_out_pkg::PIN_DQS_HIGH];
    assign dqsIdle   = ~filt[ddr_out_pkg::PIN_DQS_LOW] & ~filt[ddr_out_pkg::PIN_DQS_HIGH];
    assign dqsIdleQ  = ~filtQ[ddr_out_pkg::PIN_DQS_LOW] & ~filtQ[ddr_out_pkg::PIN_DQS_HIGH];

    // ========================================================================
    // Single rate register, also the rising-edge register at double rate
    logic [DATA_W-1:0] sdrReg;
    logic              sdrLoad;

    // Latch mode only exists at single rate; at double rate this element is always edge triggered.
    assign sdrLoad = (outMode.latchMode & ~outMode.ddrMode) ? clkHigh : clkRise;

    always_ff @(posedge clock) begin
        if (sys_rst || outRst) begin
            sdrReg <= {DATA_W{ddr_out_pkg::SDR_REG_RST}};
        end else if (outCe && sdrLoad) begin
            sdrReg <= out_data_negphase;
        end
    end

    // ========================================================================
    // Extra double rate element
    // No reset by design, so its content is unknown until the first high clock phase.
    logic [DATA_W-1:0] posLatch;

    always_ff @(posedge clock) begin
        if (clkHigh) begin
            posLatch <= out_data_posphase;
        end
    end

    // ========================================================================
    // Output multiplexer
    logic [DATA_W-1:0] next_pinOut;

    always_comb begin
        if (outMode.ddrMode) begin
            next_pinOut = clkHigh ? sdrReg : posLatch;
        end else begin
            next_pinOut = sdrReg;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_output_data <= {DATA_W{ddr_out_pkg::PIN_OUT_RST}};
        end else begin
            pin_output_data <= next_pinOut;
        end
    end

    // ========================================================================
    // Read preamble detection
    ddr_out_pkg::read_state_t rdState;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdState <= ddr_out_pkg::RD_IDLE;
        end else if (readStart) begin
            rdState <= ddr_out_pkg::RD_ARMED;
        end else begin
            unique case (rdState)
                ddr_out_pkg::RD_IDLE: begin
                    rdState <= ddr_out_pkg::RD_IDLE;
                end
                ddr_out_pkg::RD_ARMED: begin
                    if (dqsIdle) begin
                        rdState <= ddr_out_pkg::RD_SEEN_IDL;
                    end
                end
                ddr_out_pkg::RD_SEEN_IDL: begin
                    if (preambleSeen) begin
                        rdState <= ddr_out_pkg::RD_BURST;
                    end
                end
                ddr_out_pkg::RD_BURST: begin
                    rdState <= ddr_out_pkg::RD_BURST;
                end
            endcase
        end
    end

    // Only an idle-to-low step counts, so a low strobe left over from a burst never re-triggers.
    assign preambleSeen = (rdState == ddr_out_pkg::RD_SEEN_IDL) & ~readStart & dqsIdleQ & dqsLowNow;

    // ========================================================================
    // Polarity selection and synchronizing registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncFall <= ddr_out_pkg::SYNC_FALL_RST;
        end else if (preambleSeen) begin
            syncFall <= clkHigh;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            readCapture <= {DATA_W{ddr_out_pkg::READ_CAP_RST}};
        end else if (syncFall ? clkFall : clkRise) begin
            readCapture <= readData;
        end
    end

    // ========================================================================
    // Checks
    property p_sdr_rst;
        outRst |=> sdrReg == '0;
    endproperty
    a_sdr_rst: assert property (p_sdr_rst) else $error("SDR register not cleared by reset.");

    property p_sdr_ce_hold;
        !outCe && !outRst |=> $stable(sdrReg);
    endproperty
    a_sdr_ce_hold: assert property (p_sdr_ce_hold) else $error("SDR register moved without enable.");

    property p_sdr_edge;
        outCe && !outRst && clkRise && !outMode.latchMode |=> sdrReg == $past(out_data_negphase);
    endproperty
    a_sdr_edge: assert property (p_sdr_edge) else $error("Rising edge did not load negative phase data.");

    property p_latch_open;
        outCe && !outRst && clkHigh && outMode.latchMode && !outMode.ddrMode
            |=> sdrReg == $past(out_data_negphase);
    endproperty
    a_latch_open: assert property (p_latch_open) else $error("Latch not transparent while clock high.");

    property p_latch_hold;
        !outRst && !clkHigh && outMode.latchMode && !outMode.ddrMode |=> $stable(sdrReg);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch changed while clock low.");

    property p_pos_latch;
        clkHigh |=> posLatch == $past(out_data_posphase);
    endproperty
    a_pos_latch: assert property (p_pos_latch) else $error("Positive phase element missed an update.");

    property p_ddr_low_phase;
        outMode.ddrMode && !clkHigh |=> pin_output_data == $past(posLatch);
    endproperty
    a_ddr_low_phase: assert property (p_ddr_low_phase) else $error("Low phase did not show positive data.");

    property p_sdr_out;
        !outMode.ddrMode |=> pin_output_data == $past(sdrReg);
    endproperty
    a_sdr_out: assert property (p_sdr_out) else $error("SDR output does not follow register.");

    property p_rearm;
        readStart |=> rdState == ddr_out_pkg::RD_ARMED && !preambleSeen;
    endproperty
    a_rearm: assert property (p_rearm) else $error("Read start did not re-arm detection.");

    property p_pol_set;
        preambleSeen |=> syncFall == $past(clkHigh) && rdState == ddr_out_pkg::RD_BURST;
    endproperty
    a_pol_set: assert property (p_pol_set) else $error("Preamble did not set polarity.");

    property p_pol_hold;
        !preambleSeen |=> $stable(syncFall);
    endproperty
    a_pol_hold: assert property (p_pol_hold) else $error("Polarity changed inside a burst.");

    property p_preamble_cause;
        preambleSeen |-> $past(dqsIdle) && dqsLowNow;
    endproperty
    a_preamble_cause: assert property (p_preamble_cause) else $error("Preamble flagged without idle-to-low step.");

    property p_ddr_high_phase;
        outMode.ddrMode && clkHigh |=> pin_output_data == $past(sdrReg);
    endproperty
    a_ddr_high_phase: assert property (p_ddr_high_phase) else $error("High phase lost negative data.");

    property p_pos_fall_hold;
        clkFall |=> $stable(posLatch);
    endproperty
    a_pos_fall_hold: assert property (p_pos_fall_hold) else $error("Positive element moved while clock low.");

    property p_ddr_edge;
        outCe && !outRst && clkRise && outMode.ddrMode |=> sdrReg == $past(out_data_negphase);
    endproperty
    a_ddr_edge: assert property (p_ddr_edge) else $error("Double rate edge load missed.");

    property p_ddr_rise_only;
        outMode.ddrMode && !clkRise && !outRst |=> $stable(sdrReg);
    endproperty
    a_ddr_rise_only: assert property (p_ddr_rise_only) else $error("Double rate register moved off the edge.");

    property p_flop_hold;
        !outMode.latchMode && !clkRise && !outRst |=> $stable(sdrReg);
    endproperty
    a_flop_hold: assert property (p_flop_hold) else $error("Flip-flop moved off the rising edge.");

    property p_preamble_once;
        preambleSeen |=> !preambleSeen;
    endproperty
    a_preamble_once: assert property (p_preamble_once) else $error("Preamble flagged twice.");

    property p_cap_fall;
        syncFall && clkFall |=> readCapture == $past(readData);
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("Falling edge capture missed.");

    property p_cap_rise;
        !syncFall && clkRise |=> readCapture == $past(readData);
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("Rising edge capture missed.");

    property p_cap_quiet;
        !clkRise && !clkFall |=> $stable(readCapture);
    endproperty
    a_cap_quiet: assert property (p_cap_quiet) else $error("Capture moved without a clock edge.");

    property p_cap_other;
        (syncFall && clkRise) || (!syncFall && clkFall) |=> $stable(readCapture);
    endproperty
    a_cap_other: assert property (p_cap_other) else $error("Capture on the unselected edge.");

    property p_armed_wait;
        rdState == ddr_out_pkg::RD_ARMED && !readStart && !dqsIdle |=> rdState == ddr_out_pkg::RD_ARMED;
    endproperty
    a_armed_wait: assert property (p_armed_wait) else $error("Armed state left without idle strobe.");

    property p_armed_idle;
        rdState == ddr_out_pkg::RD_ARMED && !readStart && dqsIdle |=> rdState == ddr_out_pkg::RD_SEEN_IDL;
    endproperty
    a_armed_idle: assert property (p_armed_idle) else $error("Idle strobe not recorded.");

    property p_burst_stay;
        rdState == ddr_out_pkg::RD_BURST && !readStart |=> rdState == ddr_out_pkg::RD_BURST;
    endproperty
    a_burst_stay: assert property (p_burst_stay) else $error("Burst state left without read start.");

    property p_idle_stay;
        rdState == ddr_out_pkg::RD_IDLE && !readStart |=> rdState == ddr_out_pkg::RD_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("Detection armed without read start.");

endmodule : ddr_output_reg_read_polarity
`default_nettype wire

// File: ddr_out_pkg.sv
// Shared constants, types and states for the DDR output register and read polarity block.
// ============================================================================
package ddr_out_pkg;

    // ========================================================================
    // Synchroniser lanes
    localparam int PIN_IO_CLK   = 0;
    localparam int PIN_DQS_HIGH = 1;
    localparam int PIN_DQS_LOW  = 2;
    localparam int PIN_COUNT    = 3;
    localparam int SYNC_STAGES  = 3;

    // ========================================================================
    // Reset values
    localparam logic       SDR_REG_RST   = 1'h0;
    localparam logic       PIN_OUT_RST   = 1'h0;
    localparam logic       SYNC_FALL_RST = 1'h0;
    localparam logic [2:0] SYNC_RST      = 3'h0;
    localparam logic       READ_CAP_RST  = 1'h0;

    // ========================================================================
    // Types
    typedef struct packed {
        logic dqsLow;
        logic dqsHigh;
        logic ioClk;
    } pin_sample_t;

    typedef struct packed {
        logic ddrMode;
        logic latchMode;
    } out_mode_t;

    typedef enum logic [1:0] {
        RD_IDLE     = 2'h0,
        RD_ARMED    = 2'h1,
        RD_SEEN_IDL = 2'h3,
        RD_BURST    = 2'h2
    } read_state_t;

endpackage : ddr_out_pkg

// File: ddr_far_side_model.sv
// Far-side model: free-running link clock, memory strobe comparators and read data.
`timescale 1ns/100ps
`default_nettype none
module ddr_far_side_model #(
    parameter int DATA_W = 8
) (
    input  wire logic                     readGo,
    input  wire logic                     readInLow,
    output var  ddr_out_pkg::pin_sample_t pins,
    output logic [DATA_W-1:0]             readData
);
    // ==========
    // Link clock
    initial begin
        pins = '0;
        readData = DATA_W'(8'h5a);
        #1.3;
        forever begin
            #80 pins.ioClk = ~pins.ioClk;
        end
    end

    // Data moves mid-phase so it is stable around every clock edge.
    always @(pins.ioClk) begin
        #40;
        readData = {readData[DATA_W-2:0], ~readData[DATA_W-1]};
    end

    // ==========
    // Read burst
    always @(posedge readGo) begin
        if (readInLow) begin
            @(negedge pins.ioClk);
        end else begin
            @(posedge pins.ioClk);
        end
        #40;
        pins.dqsLow = 1'b1;
        #160;
        repeat (4) begin
            pins.dqsHigh = ~pins.dqsHigh;
            pins.dqsLow = ~pins.dqsLow;
            #80;
        end
        pins.dqsLow = 1'b0;
        pins.dqsHigh = 1'b0;
    end
endmodule : ddr_far_side_model
`default_nettype wire

// File: ddr_output_reg_read_polarity_tb.sv
// Testbench: output register modes and read polarity selection against a behavioural model.
`timescale 1ns/100ps
`default_nettype none
module ddr_output_reg_read_polarity_tb;
    // ==========
    // Signals
    logic clock;
    logic sys_rst;
    ddr_out_pkg::pin_sample_t pins;
    ddr_out_pkg::out_mode_t outMode;
    logic outCe;
    logic outRst;
    logic [7:0] negData;
    logic [7:0] posData;
    logic [7:0] pinOut;
    logic readStart;
    logic [7:0] readData;
    logic [7:0] readCapture;
    logic syncFall;
    logic preambleSeen;
    logic readGo;
    logic readInLow;
    logic [31:0] lfsr;
    logic [7:0] held;
    logic lastFall;
    int numErrors;
    int nTests;
    // Mode table as {ddr, latch, enable, reset}.
    logic [3:0] modeTab [7] = '{4'h2, 4'h6, 4'ha, 4'h0, 4'h5, 4'h8, 4'he};

    ddr_output_reg_read_polarity #(.DATA_W(8)) ddr_output_reg_read_polarity_inst (
        .clock(clock), .sys_rst(sys_rst), .pins(pins), .outMode(outMode), .outCe(outCe),
        .outRst(outRst), .out_data_negphase(negData), .out_data_posphase(posData),
        .pin_output_data(pinOut), .readStart(readStart), .readData(readData),
        .readCapture(readCapture), .syncFall(syncFall), .preambleSeen(preambleSeen));

    ddr_far_side_model #(.DATA_W(8)) ddr_far_side_model_inst (
        .readGo(readGo), .readInLow(readInLow), .pins(pins), .readData(readData));

    always #2 clock = ~clock;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic endOfTest();
        $display("Errors %0d, checks %0d", numErrors, nTests);
        if (numErrors == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : endOfTest

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        nTests++;
        if (seen !== expected) begin
            numErrors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // Bounded wait for a level of the link clock pin.
    task automatic wait_io(input logic level);
        int n;
        n = 0;
        while (pins.ioClk !== level && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) begin
            numErrors++;
            endOfTest();
        end
    endtask : wait_io

    task automatic do_read(input logic inLow, input logic withStart);
        int hits;
        logic [7:0] word;
        hits = 0;
        readStart <= withStart;
        readInLow <= inLow;
        readGo <= 1'b1;
        @(posedge clock);
        readStart <= 1'b0;
        readGo <= 1'b0;
        if (withStart) lastFall = ~inLow;
        repeat (200) begin
            @(posedge clock);
            if (preambleSeen === 1'b1) hits++;
        end
        check(hits[7:0], {7'h00, withStart});
        check({7'h00, syncFall}, {7'h00, lastFall});
        wait_io(lastFall);
        wait_io(~lastFall);
        word = readData;
        repeat (8) @(posedge clock);
        check(readCapture, word);
        wait_io(lastFall);
        repeat (8) @(posedge clock);
        check(readCapture, word);
    endtask : do_read

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        outMode = '0;
        outCe = 1'b0;
        outRst = 1'b0;
        negData = 8'h00;
        posData = 8'h00;
        readStart = 1'b0;
        readGo = 1'b0;
        readInLow = 1'b0;
        lfsr = 32'h09c3;
        held = 8'h00;
        lastFall = 1'b0;
        numErrors = 0;
        nTests = 0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check(pinOut, 8'h00);
        check(readCapture, 8'h00);
        check({7'h00, syncFall}, 8'h00);
        for (int i = 0; i < 28; i++) begin
            wait_io(1'b0);
            repeat (9) @(posedge clock);
            if (i > 0) check(pinOut, outMode.ddrMode ? posData : held);
            @(posedge clock);
            lfsr = lfsr_next(lfsr);
            {outMode.ddrMode, outMode.latchMode, outCe, outRst} <= modeTab[i % 7];
            negData <= lfsr[7:0];
            posData <= lfsr[15:8];
            held = modeTab[i % 7][0] ? 8'h00 : (modeTab[i % 7][1] ? lfsr[7:0] : held);
            wait_io(1'b1);
            repeat (10) @(posedge clock);
            check(pinOut, held);
            @(posedge clock);
            lfsr = lfsr_next(lfsr);
            negData <= lfsr[7:0];
            if (modeTab[i % 7] == 4'h6) held = lfsr[7:0];
            repeat (8) @(posedge clock);
            check(pinOut, held);
        end
        do_read(1'b0, 1'b1);
        do_read(1'b1, 1'b1);
        do_read(1'b0, 1'b0);
        do_read(1'b0, 1'b1);
        // A mid-run reset must clear the polarity choice and the outputs.
        outMode <= '0;
        outCe <= 1'b0;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check(pinOut, 8'h00);
        check(readCapture, 8'h00);
        check({7'h00, syncFall}, 8'h00);
        do_read(1'b0, 1'b1);
        endOfTest();
    end
endmodule : ddr_output_reg_read_polarity_tb
`default_nettype wire
